//--- rtl/pps_pkg.sv
// Constants, state codes and timing for the image stream host port.
// Assumes a single 125 MHz clock; every user writes pps_pkg::name.
package pps_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_HZ         = 125_000_000;
  localparam int ALERT_US       = 200;
  localparam int ALERT_CYCLES   = ALERT_US * (CLK_HZ / 1_000_000);
  localparam int ALERT_CNT_W    = 15;
  localparam int HOST_RESP_MS   = 500;
  localparam int WD_CYCLES      = HOST_RESP_MS * (CLK_HZ / 1_000);
  localparam int WD_CNT_W       = 26;
  localparam int PERIPH_RESP_MS = 10;
  localparam int PERIPH_SLOW_MS = 40;

  // ************************************************************
  // Negotiation values and stream content
  // ************************************************************
  localparam int         EXT_LINK_BIT   = 7;
  localparam logic [7:0] REQ_NIB_STREAM = 8'h04;
  localparam logic [7:0] REQ_ECP_STREAM = 8'h10;
  localparam logic [7:0] PAD_BYTE       = 8'hFF;
  localparam int         ESC_LEN        = 6;
  localparam logic [47:0] ESC_PACKET    = 48'hAA5500FF8778;

  // ************************************************************
  // Host status vector {nack, busy, perror, select, nfault}
  // ************************************************************
  localparam int         ST_NACK     = 4;
  localparam logic [4:0] STAT_IDLE   = 5'h13;
  localparam logic [4:0] STAT_NEG    = 5'h07;
  localparam logic [4:0] STAT_REJ    = 5'h11;
  localparam logic [4:0] STAT_STREAM = 5'h12;
  localparam logic [4:0] STAT_TERM   = 5'h03;

  // Synchronised control vector bit positions
  localparam int C_NSELIN  = 0;
  localparam int C_NSTROBE = 1;
  localparam int C_NAUTOFD = 2;
  localparam int C_NINIT   = 3;

  // Sync vector {pt status(5), host control(4), host data(8)}
  localparam logic [16:0] SYNC_INIT = 17'h1FF00;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_NEG    = 8'h02,
    ST_REJECT = 8'h04,
    ST_NIB    = 8'h08,
    ST_ECP    = 8'h10,
    ST_TERM   = 8'h20,
    ST_PASS   = 8'h40,
    ST_ALERT  = 8'h80
  } state_t;

endpackage

//--- rtl/pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs are asynchronous to clock.
module pin_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;

  // A change counts only once stages two and three agree
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff  <= INIT;
      s2_ff  <= INIT;
      s3_ff  <= INIT;
      out_ff <= INIT;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        out_ff <= s3_ff;
      end
    end
  end

  assign dout = out_ff;

endmodule

//--- rtl/two_entry_buffer.sv
// Small FIFO between the image source and the host port logic.
// Assumes the source honours in_ready; draining side may stall freely.
module two_entry_buffer #(
  parameter int W     = 9,
  parameter int DEPTH = 2
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ff;
  logic [PW-1:0] rd_ff;
  logic [CW-1:0] cnt_ff;
  logic          rdy_ff;
  wire           push    = in_valid & in_ready;
  wire           pop     = out_valid & out_ready;
  wire [CW-1:0]  nxt_cnt = CW'(cnt_ff + CW'(push) - CW'(pop));

  // Ready is registered so the source sees a flop, not count decoding
  assign in_ready  = rdy_ff;
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem[rd_ff];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
      rdy_ff <= 1'b1;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == PW'(DEPTH - 1)) ? '0 : PW'(wr_ff + 1'b1);
      end
      if (pop) begin
        rd_ff <= (rd_ff == PW'(DEPTH - 1)) ? '0 : PW'(rd_ff + 1'b1);
      end
      cnt_ff <= nxt_cnt;
      rdy_ff <= (nxt_cnt != CW'(DEPTH));
    end
  end

  // Storage needs no reset; out_valid guards every read
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ff] <= in_data;
    end
  end

endmodule

//--- rtl/pport_image_stream_passthru.sv
// Host parallel port logic for image stream upload and pass-through.
// Assumes host pins arrive asynchronously; source logic shares clock.
//
// Functional notes
// - Stream data flows only toward the host.
// - Link bit set, second value picks mode.
// - Streams end with normal termination handshake.
// - ECP byte stream or nibble stream mode.
// - Nibble stream moves byte per nAutoFd cycle.
// - Two strobe pulses mark a stream request.
// - Data ready gives 200 us nAck pulse.
// - Pad with 0xFF after frame end.
// - nAutoFd low: low nibble, then nAck low.
// - nAutoFd high: high nibble, then nAck high.
// - Pass-through echoes control out, status back.
// - Pass-through mode stays silent toward host.
// - Escape packet on data lines exits pass-through.
// - On exit, freeze pass-through control, stop echo.
// - Host step over 0.5 s in negotiation or termination trips watchdog.
// - Device answers each step within 10 ms.
// - Never stall forward channel, no recovery.
module pport_image_stream_passthru #(
  parameter int ALERT_CYCLES = pps_pkg::ALERT_CYCLES,
  parameter int WD_CYCLES    = pps_pkg::WD_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [7:0] host_data_in,
  output logic      [7:0] host_data_out,
  output logic            host_data_oe,
  input  wire logic       host_nstrobe,
  input  wire logic       host_nautofd,
  input  wire logic       host_nselectin,
  input  wire logic       host_ninit,
  output logic            host_nack,
  output logic            host_busy,
  output logic            host_perror,
  output logic            host_select,
  output logic            host_nfault,
  output logic            pt_nstrobe,
  output logic            pt_nautofd,
  output logic            pt_nselectin,
  output logic            pt_ninit,
  input  wire logic       pt_nack,
  input  wire logic       pt_busy,
  input  wire logic       pt_perror,
  input  wire logic       pt_select,
  input  wire logic       pt_nfault,
  input  wire logic       src_valid,
  output logic            src_ready,
  input  wire logic [7:0] src_data,
  input  wire logic       src_last,
  input  wire logic       frame_ready,
  input  wire logic       enter_passthrough_cmd,
  output logic            passthrough_active,
  output logic            stream_active,
  output logic            watchdog_reset
);

  // ************************************************************
  // Pin synchronisation and edge detection
  // ************************************************************
  logic [16:0] sync_out;
  logic [3:0]  c_prev_ff;
  logic [7:0]  d_prev_ff;

  pin_sync #(.W(17), .INIT(pps_pkg::SYNC_INIT)) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .din   ({pt_nack, pt_busy, pt_perror, pt_select, pt_nfault, host_ninit,
             host_nautofd, host_nstrobe, host_nselectin, host_data_in}),
    .dout  (sync_out)
  );

  wire [7:0] d_s      = sync_out[7:0];
  wire [3:0] c_s      = sync_out[11:8];
  wire [4:0] ps_s     = sync_out[16:12];
  wire       sel_rise = c_s[pps_pkg::C_NSELIN] & ~c_prev_ff[pps_pkg::C_NSELIN];
  wire       sel_fall = ~c_s[pps_pkg::C_NSELIN] & c_prev_ff[pps_pkg::C_NSELIN];
  wire       stb_rise = c_s[pps_pkg::C_NSTROBE] & ~c_prev_ff[pps_pkg::C_NSTROBE];
  wire       afd_rise = c_s[pps_pkg::C_NAUTOFD] & ~c_prev_ff[pps_pkg::C_NAUTOFD];
  wire       afd_fall = ~c_s[pps_pkg::C_NAUTOFD] & c_prev_ff[pps_pkg::C_NAUTOFD];
  wire       ctl_chg  = (c_s != c_prev_ff);

  // ************************************************************
  // Stream data path
  // ************************************************************
  logic       buf_valid;
  logic [7:0] buf_data;
  logic       buf_last;
  logic       pad_ff;
  logic       pop;

  two_entry_buffer #(.W(9), .DEPTH(2)) u_buf (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (src_valid),
    .in_ready  (src_ready),
    .in_data   ({src_last, src_data}),
    .out_valid (buf_valid),
    .out_ready (pop),
    .out_data  ({buf_last, buf_data})
  );

  wire [7:0] byte_sel = pad_ff ? pps_pkg::PAD_BYTE : buf_data;
  wire       avail    = pad_ff | buf_valid;

  // ************************************************************
  // Control state
  // ************************************************************
  pps_pkg::state_t state_ff;
  pps_pkg::state_t nxt_state;
  logic [4:0]  stat_ff;
  logic [4:0]  nxt_stat;
  logic [7:0]  dout_ff;
  logic [7:0]  nxt_dout;
  logic        oe_ff;
  logic [3:0]  pt_ctl_ff;
  logic [7:0]  req1_ff;
  logic [7:0]  req2_ff;
  logic [1:0]  stb_cnt_ff;
  logic        lo_req_ff;
  logic        held_ff;
  logic        ack_set_ff;
  logic        ack_clr_ff;
  logic [pps_pkg::ALERT_CNT_W-1:0] alert_cnt_ff;
  logic [pps_pkg::WD_CNT_W-1:0]    wd_cnt_ff;
  logic        wd_rst_ff;
  logic        stream_ff;
  logic        pass_ff;
  logic [2:0]  esc_idx_ff;

  function automatic logic [7:0] esc_byte(input logic [2:0] idx);
    esc_byte = pps_pkg::ESC_PACKET[8*(pps_pkg::ESC_LEN-1-int'(idx)) +: 8];
  endfunction

  wire is_idle = (state_ff == pps_pkg::ST_IDLE);
  wire is_neg  = (state_ff == pps_pkg::ST_NEG);
  wire is_nib  = (state_ff == pps_pkg::ST_NIB);
  wire is_ecp  = (state_ff == pps_pkg::ST_ECP);
  wire is_term = (state_ff == pps_pkg::ST_TERM);
  wire is_pass = (state_ff == pps_pkg::ST_PASS);
  wire rev_ecp = is_ecp & ~c_s[pps_pkg::C_NINIT];
  wire nxt_str = (nxt_state == pps_pkg::ST_NIB) | (nxt_state == pps_pkg::ST_ECP);

  // Host opens a negotiation with nSelectIn high and nAutoFd low
  wire neg_start = sel_rise & ~c_s[pps_pkg::C_NAUTOFD];

  // link bit and mode value checked
  // exactly two strobes mark a stream
  wire mode_ok   = (req2_ff == pps_pkg::REQ_NIB_STREAM) |
                   (req2_ff == pps_pkg::REQ_ECP_STREAM);
  wire stream_ok = (stb_cnt_ff == 2'h2) & req1_ff[pps_pkg::EXT_LINK_BIT] & mode_ok;

  // low nibble once nAutoFd is low
  wire present_lo  = is_nib & lo_req_ff & avail & ~c_s[pps_pkg::C_NAUTOFD];
  wire present_ecp = rev_ecp & avail & ~c_s[pps_pkg::C_NAUTOFD] & ~held_ff &
                     stat_ff[pps_pkg::ST_NACK];
  wire take        = held_ff & afd_rise & ~sel_fall;
  assign pop       = take & ~pad_ff;

  // host wait limit on negotiation and termination steps
  wire wd_fire   = (is_neg | is_term) &
                   (wd_cnt_ff == pps_pkg::WD_CNT_W'(WD_CYCLES - 1));
  wire alert_end = (alert_cnt_ff == pps_pkg::ALERT_CNT_W'(ALERT_CYCLES - 1));

  // escape bytes seen with strobe held high
  wire data_chg = (d_s != d_prev_ff);
  wire quiet    = c_s[pps_pkg::C_NSTROBE];
  wire esc_hit  = (d_s == esc_byte(esc_idx_ff));
  wire esc_done = is_pass & data_chg & quiet & esc_hit &
                  (esc_idx_ff == 3'(pps_pkg::ESC_LEN - 1));
  wire [2:0] nxt_esc = !is_pass || !quiet ? 3'h0 :
                       !data_chg ? esc_idx_ff :
                       esc_hit ? 3'(esc_idx_ff + 3'h1) :
                       (d_s == esc_byte(3'h0)) ? 3'h1 : 3'h0;

  // ************************************************************
  // Next-state and host status
  // ************************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_stat  = stat_ff;
    nxt_dout  = dout_ff;
    case (state_ff)
      pps_pkg::ST_IDLE: begin
        if (enter_passthrough_cmd) begin
          nxt_state = pps_pkg::ST_PASS;
        end else if (neg_start) begin
          nxt_state = pps_pkg::ST_NEG;
          nxt_stat  = pps_pkg::STAT_NEG;
        end else if (frame_ready) begin
          nxt_state = pps_pkg::ST_ALERT;
          nxt_stat[pps_pkg::ST_NACK] = 1'b0;
        end
      end
      pps_pkg::ST_NEG: begin
        if (wd_fire || sel_fall) begin
          nxt_state = pps_pkg::ST_IDLE;
          nxt_stat  = pps_pkg::STAT_IDLE;
        end else if (afd_rise) begin
          // mode chosen by second request value
          nxt_stat  = stream_ok ? pps_pkg::STAT_STREAM : pps_pkg::STAT_REJ;
          nxt_state = !stream_ok ? pps_pkg::ST_REJECT :
                      (req2_ff == pps_pkg::REQ_ECP_STREAM) ? pps_pkg::ST_ECP :
                      pps_pkg::ST_NIB;
        end
      end
      pps_pkg::ST_REJECT, pps_pkg::ST_NIB, pps_pkg::ST_ECP: begin
        if (sel_fall) begin
          nxt_state = pps_pkg::ST_TERM;
          nxt_stat  = pps_pkg::STAT_TERM;
        end else if (is_nib) begin
          if (present_lo) begin
            nxt_stat[3:0] = byte_sel[3:0];
          end else if (ack_set_ff) begin
            nxt_stat[pps_pkg::ST_NACK] = 1'b0;
          end else if (take) begin
            nxt_stat[3:0] = byte_sel[7:4];
          end else if (ack_clr_ff) begin
            nxt_stat[pps_pkg::ST_NACK] = 1'b1;
          end
        end else if (is_ecp) begin
          if (present_ecp) begin
            nxt_dout = byte_sel;
          end else if (ack_set_ff) begin
            nxt_stat[pps_pkg::ST_NACK] = 1'b0;
          end else if (take) begin
            nxt_stat[pps_pkg::ST_NACK] = 1'b1;
          end
        end
      end
      pps_pkg::ST_TERM: begin
        if (wd_fire || afd_rise) begin
          nxt_state = pps_pkg::ST_IDLE;
          nxt_stat  = pps_pkg::STAT_IDLE;
        end
      end
      pps_pkg::ST_PASS: begin
        if (esc_done) begin
          nxt_state = pps_pkg::ST_IDLE;
          nxt_stat  = pps_pkg::STAT_IDLE;
        end else begin
          nxt_stat = ps_s;
        end
      end
      pps_pkg::ST_ALERT: begin
        if (alert_end) begin
          nxt_state = pps_pkg::ST_IDLE;
          nxt_stat[pps_pkg::ST_NACK] = 1'b1;
        end
      end
      default: begin
        nxt_state = pps_pkg::ST_IDLE;
        nxt_stat  = pps_pkg::STAT_IDLE;
      end
    endcase
  end

  // data lines driven only in reverse ECP
  // forward strobes never answered with busy
  wire nxt_oe = (nxt_state == pps_pkg::ST_ECP) & ~c_s[pps_pkg::C_NINIT];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= pps_pkg::ST_IDLE;
      stat_ff  <= pps_pkg::STAT_IDLE;
      dout_ff  <= 8'h00;
      oe_ff    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      stat_ff  <= nxt_stat;
      dout_ff  <= nxt_dout;
      oe_ff    <= nxt_oe;
    end
  end

  // ************************************************************
  // Handshake bookkeeping
  // ************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      c_prev_ff  <= 4'hF;
      d_prev_ff  <= 8'h00;
      req1_ff    <= 8'h00;
      req2_ff    <= 8'h00;
      stb_cnt_ff <= 2'h0;
      lo_req_ff  <= 1'b0;
      held_ff    <= 1'b0;
      ack_set_ff <= 1'b0;
      ack_clr_ff <= 1'b0;
      esc_idx_ff <= 3'h0;
    end else begin
      c_prev_ff  <= c_s;
      d_prev_ff  <= d_s;
      ack_set_ff <= present_lo | present_ecp;
      ack_clr_ff <= take & is_nib;
      esc_idx_ff <= nxt_esc;
      lo_req_ff  <= nxt_str & ((afd_fall & is_nib) | (lo_req_ff & ~present_lo));
      held_ff    <= nxt_str & ((present_lo | present_ecp) | (held_ff & ~take));
      if (is_idle) begin
        stb_cnt_ff <= 2'h0;
      end else if (is_neg && stb_rise && stb_cnt_ff != 2'h3) begin
        stb_cnt_ff <= 2'(stb_cnt_ff + 2'h1);
        if (stb_cnt_ff == 2'h0) begin
          req1_ff <= d_s;
        end
        if (stb_cnt_ff == 2'h1) begin
          req2_ff <= d_s;
        end
      end
    end
  end

  // ************************************************************
  // Timers, padding and pass-through latches
  // ************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alert_cnt_ff <= '0;
      wd_cnt_ff    <= '0;
      wd_rst_ff    <= 1'b0;
      pad_ff       <= 1'b0;
      pt_ctl_ff    <= 4'hF;
      stream_ff    <= 1'b0;
      pass_ff      <= 1'b0;
    end else begin
      alert_cnt_ff <= (state_ff == pps_pkg::ST_ALERT) ?
                      pps_pkg::ALERT_CNT_W'(alert_cnt_ff + 1'b1) : '0;
      wd_cnt_ff    <= (ctl_chg || !(is_neg || is_term)) ? '0 :
                      pps_pkg::WD_CNT_W'(wd_cnt_ff + 1'b1);
      wd_rst_ff    <= wd_fire;
      // The last byte starts padding and wins over a new frame announcement
      if (pop && buf_last) begin
        pad_ff <= 1'b1;
      end else if (is_idle && frame_ready && !enter_passthrough_cmd && !neg_start) begin
        pad_ff <= 1'b0;
      end
      if (is_pass) begin
        pt_ctl_ff <= c_s;
      end
      stream_ff <= nxt_str;
      pass_ff   <= (nxt_state == pps_pkg::ST_PASS);
    end
  end

  assign host_data_out      = dout_ff;
  assign host_data_oe       = oe_ff;
  assign host_nack          = stat_ff[4];
  assign host_busy          = stat_ff[3];
  assign host_perror        = stat_ff[2];
  assign host_select        = stat_ff[1];
  assign host_nfault        = stat_ff[0];
  assign pt_nselectin       = pt_ctl_ff[pps_pkg::C_NSELIN];
  assign pt_nstrobe         = pt_ctl_ff[pps_pkg::C_NSTROBE];
  assign pt_nautofd         = pt_ctl_ff[pps_pkg::C_NAUTOFD];
  assign pt_ninit           = pt_ctl_ff[pps_pkg::C_NINIT];
  assign passthrough_active = pass_ff;
  assign stream_active      = stream_ff;
  assign watchdog_reset     = wd_rst_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_lo_shown;
    host_nfault == $past(byte_sel[0]) && host_busy == $past(byte_sel[3]);
  endsequence
  sequence s_hi_shown;
    {host_busy, host_perror, host_select, host_nfault} == $past(byte_sel[7:4]);
  endsequence

  a_fwd_no_drive: assert property (host_data_oe |-> state_ff == pps_pkg::ST_ECP)
    else $error("data lines driven outside reverse ECP");
  a_stream_link: assert property (is_neg && nxt_str |-> req1_ff[pps_pkg::EXT_LINK_BIT])
    else $error("stream entered without link request bit");
  a_term_release: assert property (is_term && afd_rise |=> is_idle && host_nack)
    else $error("termination did not complete");
  a_ecp_select: assert property ((is_neg && nxt_state == pps_pkg::ST_ECP)
      |-> req2_ff == pps_pkg::REQ_ECP_STREAM)
    else $error("ECP stream without ECP request value");
  a_double_strobe: assert property (is_neg && nxt_str |-> stb_cnt_ff == 2'h2)
    else $error("stream entered without two strobes");
  a_alert_width: assert property ($rose(host_nack) && $past(state_ff) == pps_pkg::ST_ALERT
      |-> $past(alert_cnt_ff) == pps_pkg::ALERT_CNT_W'(ALERT_CYCLES - 1))
    else $error("data ready pulse has wrong width");
  a_pad_after_last: assert property (pop && buf_last |=> pad_ff && byte_sel == 8'hFF)
    else $error("no padding after last byte");
  a_low_nibble: assert property (present_lo |=> s_lo_shown ##1 !host_nack)
    else $error("low nibble handshake broken");
  a_high_nibble: assert property (take && is_nib |=> s_hi_shown ##1 host_nack)
    else $error("high nibble handshake broken");
  a_pass_echo: assert property ($past(is_pass) && is_pass
      |-> stat_ff == $past(ps_s) && pt_ctl_ff == $past(c_s))
    else $error("pass-through echo wrong");
  a_pass_silent: assert property (is_pass |-> !host_data_oe && !stream_active)
    else $error("device active during pass-through");
  a_escape_exit: assert property (esc_done |=> is_idle && !passthrough_active)
    else $error("escape packet did not leave pass-through");
  a_pt_frozen: assert property (!is_pass |=> $stable(pt_ctl_ff))
    else $error("pass-through control moved outside pass-through");
  a_watchdog: assert property (wd_fire |=> watchdog_reset && is_idle)
    else $error("watchdog did not fire");
  a_ecp_answer: assert property (present_ecp |-> ##[1:4] !host_nack)
    else $error("slow device answer");
  a_no_stall: assert property (is_ecp |-> !host_busy)
    else $error("busy raised in ECP stream");

endmodule

//--- test/pt_printer.sv
// Stand-in for the printer chained behind the pass-through port.
// Assumes the host port logic drives its control pins from one clock.
module pt_printer (
  input  wire logic pt_nstrobe,
  input  wire logic pt_nautofd,
  output logic      pt_nack,
  output logic      pt_busy,
  output logic      pt_perror,
  output logic      pt_select,
  output logic      pt_nfault
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Status answers
  // ************************************************************
  // Ack tracks autofeed so an echo through both directions shows up
  assign pt_nack   = pt_nautofd;
  assign pt_busy   = ~pt_nstrobe;
  assign pt_perror = 1'b0;
  assign pt_select = 1'b1;
  assign pt_nfault = 1'b1;
endmodule

//--- test/tb.sv
// Testbench: data-ready pulse, nibble stream with padding, ECP stream,
// termination, watchdog and pass-through. Assumes pt_printer.sv first.
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: %h %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Signals
  // ************************************************************
  logic       clock = 0, rst_n = 0, host_data_oe, src_ready, watchdog_reset;
  logic [7:0] host_data_in = 8'h00, src_data = 8'hA5, host_data_out;
  logic       host_nstrobe = 1, host_nautofd = 1, host_nselectin = 0, host_ninit = 1;
  logic       src_valid = 1, src_last = 1, frame_ready = 0, enter_passthrough_cmd = 0;
  logic       pt_nstrobe, pt_nautofd, pt_nselectin, pt_ninit, pt_nack, pt_busy;
  logic       pt_perror, pt_select, pt_nfault, passthrough_active, stream_active;
  logic       host_nack, host_busy, host_perror, host_select, host_nfault;
  int         err_count = 0;
  int         comparisons = 0;
  wire  [4:0] status = {host_nack, host_busy, host_perror, host_select, host_nfault};

  pport_image_stream_passthru #(.ALERT_CYCLES(20), .WD_CYCLES(200)) dut (.*);
  pt_printer prn (.*);

  always #4 clock = ~clock;
  // Source offers one byte, the last of its frame
  always @(posedge clock) if (rst_n && src_valid && src_ready) src_valid <= 1'b0;

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic w(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic strobe(input logic [7:0] b);
    host_data_in <= b;
    w(3);
    host_nstrobe <= 1'b0;
    w(6);
    host_nstrobe <= 1'b1;
    w(6);
  endtask
  task automatic nib(input logic [7:0] b);
    host_nautofd <= 1'b0;
    w(10);
    `CHK(status, {1'b0, b[3:0]})
    host_nautofd <= 1'b1;
    w(10);
    `CHK(status, {1'b1, b[7:4]})
  endtask
  task automatic t_alert;
    frame_ready <= 1'b1;
    w(1);
    frame_ready <= 1'b0;
    w(10);
    `CHK(host_nack, 1'b0)
    w(14);
    `CHK(status, pps_pkg::STAT_IDLE)
    $display("alert test done");
  endtask
  task automatic negotiate(input logic [7:0] mode);
    host_nautofd <= 1'b0;
    w(2);
    host_nselectin <= 1'b1;
    w(8);
    `CHK(status, pps_pkg::STAT_NEG)
    strobe(8'h80);
    strobe(mode);
    host_nautofd <= 1'b1;
    w(8);
    `CHK(status, pps_pkg::STAT_STREAM)
    `CHK(stream_active, 1'b1)
  endtask
  task automatic t_stream;
    negotiate(pps_pkg::REQ_NIB_STREAM);
    `CHK(host_data_oe, 1'b0)
    nib(8'hA5);
    repeat (4) nib(pps_pkg::PAD_BYTE);
    host_nselectin <= 1'b0;
    w(8);
    `CHK(status, pps_pkg::STAT_TERM)
    `CHK(stream_active, 1'b0)
    host_nautofd <= 1'b0;
    w(8);
    host_nautofd <= 1'b1;
    w(8);
    `CHK(status, pps_pkg::STAT_IDLE)
    $display("stream test done");
  endtask
  task automatic t_ecp;
    src_data <= 8'h3C;
    src_valid <= 1'b1;
    frame_ready <= 1'b1;
    w(1);
    frame_ready <= 1'b0;
    w(24);
    negotiate(pps_pkg::REQ_ECP_STREAM);
    host_ninit <= 1'b0;
    host_nautofd <= 1'b0;
    w(10);
    `CHK(host_data_oe, 1'b1)
    `CHK(host_data_out, 8'h3C)
    `CHK(status, {1'b0, pps_pkg::STAT_STREAM[3:0]})
    host_nautofd <= 1'b1;
    w(10);
    `CHK(status, pps_pkg::STAT_STREAM)
    // Host stalls in termination until the watchdog gives up
    host_nselectin <= 1'b0;
    host_ninit <= 1'b1;
    w(205);
    `CHK(watchdog_reset, 1'b0)
    w(1);
    `CHK(watchdog_reset, 1'b1)
    `CHK(status, pps_pkg::STAT_IDLE)
    $display("ECP and watchdog test done");
  endtask
  task automatic t_pass;
    enter_passthrough_cmd <= 1'b1;
    w(1);
    enter_passthrough_cmd <= 1'b0;
    w(2);
    `CHK(passthrough_active, 1'b1)
    host_ninit <= 1'b0;
    host_nautofd <= 1'b0;
    w(12);
    `CHK(pt_ninit, 1'b0)
    `CHK(host_nack, 1'b0)
    `CHK(host_busy, 1'b0)
    for (int i = 5; i >= 0; i--) begin
      host_data_in <= pps_pkg::ESC_PACKET[i*8 +: 8];
      w(8);
    end
    w(4);
    `CHK(passthrough_active, 1'b0)
    host_ninit <= 1'b1;
    host_nautofd <= 1'b1;
    w(10);
    `CHK({pt_ninit, pt_nautofd}, 2'b00)
    `CHK(status, pps_pkg::STAT_IDLE)
    $display("pass-through test done");
  endtask

  // ************************************************************
  // Sequence and watchdog
  // ************************************************************
  initial begin
    w(8);
    rst_n <= 1'b1;
    w(8);
    `CHK(status, pps_pkg::STAT_IDLE)
    t_alert();
    t_stream();
    t_ecp();
    t_pass();
    give_verdict();
  end
  initial begin
    w(5000);
    err_count++;
    give_verdict();
  end
endmodule
